// [src/sahl_host.sv]
// host controller for a serial sar converter link, with an ahb-lite register port
//
// Overview of operation
// - the controller watches the converter busy line before it opens its slave receiver.
// - the slave receiver is enabled only after a high-to-low edge on busy, keeping words aligned.
// - with the converter as master, data is taken on the falling edge of the converter clock.
// - in host mode the result is read from the parallel msb pin, and both selects idle high.
// - the first queue entry is 8 bits long with both selects low, starting a conversion.
// - the second queue entry is 16 bits long with only select one low, reading the result.
// - after each queue entry the controller waits a post-transfer delay of 19 us.
// - the queue wraps from the read entry back to the start entry while running.
// - the fastest setting is a serial clock near 4.19 MHz with the shortest delay; the code defaults to about 4.55 MHz and accepts faster.
// - lower sample rates come from a longer delay, never from other timing.
// - the serial clock is never made slower than its default rate.
// - the serial clock idles low and data is captured on its rising edge.
// - queue entries are described by command bytes 20h for start and 61h for read.
// - the upper result byte is never lost to the lower one; the full word is held at once.
// - converter inputs stay static during the delay that covers the late bit decisions.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module sahl_host #(
  parameter int DATA_W = 16
) (
  // system clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter as master: its clock, data and busy line
  input wire logic external_shift_clock,
  input wire logic serial_result_out,
  input wire logic start_sample_n_busy,
  // host as master: selects, serial clock and the shared data input
  output logic peripheral_select_zero,
  output logic peripheral_select_one,
  output logic host_sck,
  input wire logic parallel_msb_pin
);
  typedef struct packed {
    sahl_pkg::sahl_state_t st;
    logic entry;
    logic [4:0] bitcnt;
    logic [15:0] div;
    logic [15:0] gap;
    logic sck;
    logic sel0;
    logic sel1;
    logic [DATA_W-1:0] shift;
    logic [DATA_W-1:0] result;
    logic valid;
    logic overrun;
    logic run;
    logic mode;
    logic [15:0] delay;
    logic [15:0] half;
    logic [1:0] pin_s;
    logic [1:0] busy_s;
    logic busy_prev;
    logic rx_en;
    logic [2:0] tgl_s;
    logic ap_act;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } sahl_host_t;

  sahl_host_t q, d;
  logic [DATA_W-1:0] rx_word;
  logic rx_tgl;
  logic busy_fell;
  logic rx_done;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic ap_take;

  initial assert (DATA_W >= 2 && DATA_W <= 16) else $error("sahl_host: DATA_W out of range");

  // command byte of a queue entry
  function automatic logic [7:0] entry_cmd(input logic entry);
    entry_cmd = entry ? sahl_pkg::CMD_READ : sahl_pkg::CMD_START;
  endfunction : entry_cmd

  // bit count of an entry, taken from its width field
  function automatic logic [4:0] entry_len(input logic [7:0] c);
    entry_len = c[sahl_pkg::CMD_WIDE] ? sahl_pkg::LEN_WIDE : sahl_pkg::LEN_NARROW;
  endfunction : entry_len

  // receiver that runs on the converter clock
  sahl_link_rx #(
    .WORD_W(DATA_W)
  ) u_rx (
    .external_shift_clock(external_shift_clock),
    .hresetn(hresetn),
    .rx_en(q.rx_en),
    .serial_result_out(serial_result_out),
    .word_q(rx_word),
    .done_tgl_q(rx_tgl)
  );

  // decoded events from synchronised inputs
  assign busy_fell = q.busy_prev & ~q.busy_s[1];
  assign rx_done = q.tgl_s[2] ^ q.tgl_s[1];
  assign cmd = entry_cmd(q.entry);
  assign next_cmd = entry_cmd(~q.entry); // selects of the entry that follows the gap
  assign ap_take = hsel & hready & htrans[1];

  // next state: bus slave, queue sequencer and slave listener
  always_comb
  begin
    d = q;
    d.pin_s = {q.pin_s[0], parallel_msb_pin};
    d.busy_s = {q.busy_s[0], start_sample_n_busy};
    d.busy_prev = q.busy_s[1];
    d.tgl_s = {q.tgl_s[1:0], rx_tgl};
    // address phase capture; reads answer from a flop in the data phase
    d.ap_act = ap_take;
    d.ap_write = hwrite;
    d.ap_addr = haddr[7:0];
    d.rdata = 32'h0000_0000;
    if (ap_take && !hwrite)
    begin
      unique case (haddr[7:0])
        sahl_pkg::OFS_CTRL:
        begin
          d.rdata[sahl_pkg::CTRL_RUN] = q.run;
          d.rdata[sahl_pkg::CTRL_MODE] = q.mode;
        end
        sahl_pkg::OFS_STATUS:
        begin
          d.rdata[sahl_pkg::ST_VALID] = q.valid;
          d.rdata[sahl_pkg::ST_OVERRUN] = q.overrun;
          d.rdata[sahl_pkg::ST_ACTIVE] = (q.st != sahl_pkg::S_IDLE);
          d.rdata[sahl_pkg::ST_LISTEN] = q.rx_en;
        end
        sahl_pkg::OFS_RESULT:
        begin
          d.rdata[DATA_W-1:0] = q.result;
          d.valid = 1'b0;
          d.overrun = 1'b0;
        end
        sahl_pkg::OFS_DELAY: d.rdata[15:0] = q.delay;
        sahl_pkg::OFS_HALF: d.rdata[15:0] = q.half;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // data phase writes; unmapped offsets are ignored
    if (q.ap_act && q.ap_write)
    begin
      unique case (q.ap_addr)
        sahl_pkg::OFS_CTRL:
        begin
          d.run = hwdata[sahl_pkg::CTRL_RUN];
          d.mode = hwdata[sahl_pkg::CTRL_MODE];
        end
        sahl_pkg::OFS_DELAY: d.delay = hwdata[15:0];
        // a slower clock is refused by clamping to the default rate
        sahl_pkg::OFS_HALF: d.half = (hwdata[15:0] == 16'h0000) ? 16'h0001
          : (hwdata[15:0] > sahl_pkg::HALF_CYC) ? sahl_pkg::HALF_CYC : hwdata[15:0];
        default: d.run = q.run;
      endcase
    end
    // sequencer
    unique case (q.st)
      sahl_pkg::S_IDLE:
      begin
        if (q.run && q.mode)
        begin
          d.st = sahl_pkg::S_XFER;
          d.entry = 1'b0;
          d.bitcnt = 5'h00;
          d.div = q.half - 16'h0001;
          d.sel0 = sahl_pkg::CMD_START[sahl_pkg::CMD_SEL0];
          d.sel1 = sahl_pkg::CMD_START[sahl_pkg::CMD_SEL1];
        end
        else if (q.run)
        begin
          d.st = sahl_pkg::S_ARM;
        end
      end
      sahl_pkg::S_XFER:
      begin
        if (q.div != 16'h0000)
        begin
          d.div = q.div - 16'h0001;
        end
        else
        begin
          d.div = q.half - 16'h0001;
          d.sck = ~q.sck;
          if (!q.sck)
          begin
            d.shift = {q.shift[DATA_W-2:0], q.pin_s[1]};
          end
          else if (q.bitcnt == entry_len(cmd) - 5'h01)
          begin
            // end of entry: release both selects and hold everything still
            d.st = sahl_pkg::S_GAP;
            d.sel0 = 1'b1;
            d.sel1 = 1'b1;
            d.gap = q.delay;
            if (q.entry)
            begin
              d.result = q.shift;
              d.valid = 1'b1;
              d.overrun = q.valid | q.overrun;
            end
          end
          else
          begin
            d.bitcnt = q.bitcnt + 5'h01;
          end
        end
      end
      sahl_pkg::S_GAP:
      begin
        if (q.gap != 16'h0000)
        begin
          d.gap = q.gap - 16'h0001;
        end
        else if (q.run && q.mode)
        begin
          d.st = sahl_pkg::S_XFER;
          d.entry = ~q.entry;
          d.bitcnt = 5'h00;
          d.div = q.half - 16'h0001;
          d.sel0 = next_cmd[sahl_pkg::CMD_SEL0]; // next entry is the other one
          d.sel1 = next_cmd[sahl_pkg::CMD_SEL1];
        end
        else
        begin
          d.st = sahl_pkg::S_IDLE;
        end
      end
      sahl_pkg::S_ARM:
      begin
        if (!q.run || q.mode)
        begin
          d.st = sahl_pkg::S_IDLE;
        end
        else if (busy_fell)
        begin
          d.st = sahl_pkg::S_LISTEN;
          d.rx_en = 1'b1;
        end
      end
      sahl_pkg::S_LISTEN:
      begin
        if (!q.run || q.mode)
        begin
          d.st = sahl_pkg::S_IDLE;
          d.rx_en = 1'b0;
        end
      end
    endcase
    // word from the link; it changes with the toggle and then stays stable for many host cycles
    if (rx_done && q.rx_en)
    begin
      d.result = rx_word;
      d.valid = 1'b1;
      d.overrun = q.valid | q.overrun;
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.st <= sahl_pkg::S_IDLE;
      q.sel0 <= 1'b1;
      q.sel1 <= 1'b1;
      q.run <= sahl_pkg::CTRL_RUN_RST;
      q.mode <= sahl_pkg::CTRL_MODE_RST;
      q.delay <= sahl_pkg::DT_CYC;
      q.half <= sahl_pkg::HALF_CYC;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign peripheral_select_zero = q.sel0;
  assign peripheral_select_one = q.sel1;
  assign host_sck = q.sck;

  property p_start_sel;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == sahl_pkg::S_XFER && !q.entry) |-> (!peripheral_select_zero && !peripheral_select_one);
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("start entry selects wrong");

  property p_read_sel;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == sahl_pkg::S_XFER && q.entry) |-> (peripheral_select_zero && !peripheral_select_one);
  endproperty
  a_read_sel: assert property (p_read_sel) else $error("read entry selects wrong");

  property p_idle_sel;
    @(posedge hclk) disable iff (!hresetn)
    (q.st != sahl_pkg::S_XFER) |-> (peripheral_select_zero && peripheral_select_one);
  endproperty
  a_idle_sel: assert property (p_idle_sel) else $error("selects low outside a transfer");

  property p_sck_idle;
    @(posedge hclk) disable iff (!hresetn)
    (q.st != sahl_pkg::S_XFER) |-> !host_sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock not idle low");

  property p_gap_static;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == sahl_pkg::S_GAP && q.gap != 16'h0000) |=>
      ($stable(peripheral_select_zero) && $stable(peripheral_select_one) && $stable(host_sck));
  endproperty
  a_gap_static: assert property (p_gap_static) else $error("pins moved during delay");

  property p_gap_after;
    @(posedge hclk) disable iff (!hresetn)
    $fell(q.st == sahl_pkg::S_XFER) |-> (q.st == sahl_pkg::S_GAP && q.gap == $past(q.delay));
  endproperty
  a_gap_after: assert property (p_gap_after) else $error("delay not loaded after entry");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (q.st == sahl_pkg::S_GAP && q.gap == 16'h0000 && q.run && q.mode && q.entry) |=>
      (q.st == sahl_pkg::S_XFER && !q.entry);
  endproperty
  a_wrap: assert property (p_wrap) else $error("queue did not wrap");

  property p_arm;
    @(posedge hclk) disable iff (!hresetn)
    $rose(q.rx_en) |-> $past(busy_fell);
  endproperty
  a_arm: assert property (p_arm) else $error("receiver enabled without busy fall");

  property p_half_max;
    @(posedge hclk) disable iff (!hresetn)
    (q.half <= sahl_pkg::HALF_CYC) && (q.half != 16'h0000);
  endproperty
  a_half_max: assert property (p_half_max) else $error("serial clock slower than default");
endmodule : sahl_host

// [src/sahl_pkg.sv]
// package: register map, field positions, timing and queue commands for the host link
package sahl_pkg;
  // register byte offsets on the ahb-lite port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0C;
  localparam logic [7:0] OFS_HALF = 8'h10;
  // control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE = 1;
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic CTRL_MODE_RST = 1'b0;
  // status fields
  localparam int ST_VALID = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_LISTEN = 3;
  // timing: host clock, post transfer gap, serial clock
  localparam int CLK_HZ = 100000000;
  localparam int CLK_NS = 10;
  localparam int DT_NS = 19000;
  localparam logic [15:0] DT_CYC = 16'(DT_NS / CLK_NS);
  localparam int SCK_HZ = 4190000;
  localparam int HALF_RAW = CLK_HZ / (2 * SCK_HZ);
  localparam logic [15:0] HALF_CYC = 16'((HALF_RAW < 1) ? 1 : HALF_RAW);
  // queue command bytes: start entry and read entry
  localparam logic [7:0] CMD_START = 8'h20;
  localparam logic [7:0] CMD_READ = 8'h61;
  // command byte fields
  localparam int CMD_SEL0 = 0;
  localparam int CMD_SEL1 = 1;
  localparam int CMD_WIDE = 6;
  localparam logic [4:0] LEN_NARROW = 5'h08;
  localparam logic [4:0] LEN_WIDE = 5'h10;
  // controller states
  typedef enum logic [2:0] {S_IDLE, S_XFER, S_GAP, S_ARM, S_LISTEN} sahl_state_t;
endpackage : sahl_pkg

// [src/sahl_link_rx.sv]
// link-clock receiver for the arrangement where the converter drives the shift clock
`timescale 1ns/100ps
module sahl_link_rx #(
  parameter int WORD_W = 16
) (
  // link clock from the converter and the async reset
  input wire logic external_shift_clock,
  input wire logic hresetn,
  // enable from the host clock domain
  input wire logic rx_en,
  // serial data, launched on the link clock
  input wire logic serial_result_out,
  // received word and its completion toggle
  output logic [WORD_W-1:0] word_q,
  output logic done_tgl_q
);
  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [4:0] cnt;
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] word;
    logic tgl;
  } sahl_rx_t;

  sahl_rx_t q, d;

  initial assert (WORD_W >= 2 && WORD_W <= 16) else $error("sahl_link_rx: WORD_W out of range");

  // shift msb first; the word is frozen until the next word completes, which
  // leaves the host side many link cycles to take it after seeing the toggle
  always_comb
  begin
    d = q;
    d.en_s1 = rx_en;
    d.en_s2 = q.en_s1;
    if (!q.en_s2)
    begin
      d.cnt = 5'h00;
    end
    else
    begin
      d.shift = {q.shift[WORD_W-2:0], serial_result_out};
      if (q.cnt == 5'(WORD_W - 1))
      begin
        d.word = {q.shift[WORD_W-2:0], serial_result_out};
        d.tgl = ~q.tgl;
        d.cnt = 5'h00;
      end
      else
      begin
        d.cnt = q.cnt + 5'h01;
      end
    end
  end

  // data is valid on the falling edge, so the capture runs on that edge
  always_ff @(negedge external_shift_clock or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign word_q = q.word;
  assign done_tgl_q = q.tgl;
endmodule : sahl_link_rx

// [verification/sahl_start_sample_n_model.sv]
// converter model: answers the host selects and acts as shift-clock master on demand
`timescale 1ns/100ps
module sahl_start_sample_n_model (
  // host-driven pins
  input wire logic peripheral_select_zero,
  input wire logic peripheral_select_one,
  input wire logic host_sck,
  // value the next conversion returns
  input wire logic [15:0] sample,
  // converter-driven pins
  output logic parallel_msb_pin,
  output logic external_shift_clock,
  output logic serial_result_out,
  output logic start_sample_n_busy
);
  logic [15:0] result_q;
  int bit_idx;

  // pins at rest; the shift clock stands still outside frames
  initial
  begin
    result_q = 16'h0000;
    bit_idx = 0;
    parallel_msb_pin = 1'b0;
    external_shift_clock = 1'b0;
    serial_result_out = 1'b0;
    start_sample_n_busy = 1'b0;
  end

  // both selects low starts a conversion, select one alone opens the readout
  always @(negedge peripheral_select_one)
  begin
    #1;
    if (!peripheral_select_zero)
      result_q = sample;
    else
    begin
      bit_idx = 15;
      parallel_msb_pin = result_q[15];
    end
  end

  // next bit on each falling clock, so it is settled for the rising capture edge
  always @(negedge host_sck)
  begin
    if (!peripheral_select_one && peripheral_select_zero && bit_idx > 0)
    begin
      bit_idx--;
      parallel_msb_pin = result_q[bit_idx];
    end
  end

  // a deselected pin floats: show the inverse so a stale value never looks right
  always @(posedge peripheral_select_one)
    parallel_msb_pin = ~parallel_msb_pin;

  // one conversion as clock master: busy, two lead-in clocks, then the word
  task automatic frame(input logic [15:0] w);
    int i;
    start_sample_n_busy = 1'b1;
    #2000;
    start_sample_n_busy = 1'b0;
    #200;
    for (i = 17; i >= 0; i--)
    begin
      external_shift_clock = 1'b1;
      serial_result_out = (i < 16) ? w[i] : ~serial_result_out;
      #80;
      external_shift_clock = 1'b0;
      #80;
    end
    serial_result_out = ~serial_result_out;
  endtask : frame
endmodule : sahl_start_sample_n_model

// [verification/tb.sv]
// testbench: register access, host-initiated queue and converter-master reception
`timescale 1ns/100ps
module tb;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic external_shift_clock;
  logic serial_result_out;
  logic start_sample_n_busy;
  logic peripheral_select_zero;
  logic peripheral_select_one;
  logic host_sck;
  logic parallel_msb_pin;
  logic [15:0] sample;
  logic [31:0] rd;
  logic s0;
  logic gap_ok;
  int dly;
  int rises;
  int cyc;
  int n_errors;
  int compares;
  realtime t_rel;

  sahl_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_shift_clock(external_shift_clock),
    .serial_result_out(serial_result_out), .start_sample_n_busy(start_sample_n_busy),
    .peripheral_select_zero(peripheral_select_zero),
    .peripheral_select_one(peripheral_select_one), .host_sck(host_sck),
    .parallel_msb_pin(parallel_msb_pin));

  sahl_start_sample_n_model start_sample_n (.peripheral_select_zero(peripheral_select_zero),
    .peripheral_select_one(peripheral_select_one), .host_sck(host_sck), .sample(sample),
    .parallel_msb_pin(parallel_msb_pin), .external_shift_clock(external_shift_clock),
    .serial_result_out(serial_result_out), .start_sample_n_busy(start_sample_n_busy));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one single ahb-lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask : bus

  // poll status until a word is held, bounded so a dead link is reported
  task automatic wait_valid();
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[sahl_pkg::ST_VALID] !== 1'b1 && k < 3000)
    begin
      bus(1'b0, sahl_pkg::OFS_STATUS, 32'h0);
      k++;
    end
    chk("status valid", 32'h1, {31'h0, rd[sahl_pkg::ST_VALID]});
  endtask : wait_valid

  task automatic test_done();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // clock at 100 mhz
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // link monitor: clocks per entry, idle level and the quiet gap between entries
  always @(posedge host_sck) rises++;
  // select and clock change on one edge, so look a little later to avoid a race
  always @(posedge peripheral_select_one)
  begin
    t_rel = $realtime;
    #1;
    if (hresetn === 1'b1)
    begin
      chk("sck rises", s0 ? 32'h10 : 32'h8, rises);
      chk("sck idle", 32'h0, {31'h0, host_sck});
      gap_ok = 1'b1;
    end
    rises = 0;
  end
  always @(negedge peripheral_select_one)
  begin
    chk("sck idle", 32'h0, {31'h0, host_sck});
    chk("gap quiet", 32'h0, rises);
    cyc = int'(($realtime - t_rel) / 10.0);
    if (gap_ok)
      chk("gap cycles", 32'h1, {31'h0, (cyc == dly + 1) || (cyc == dly + 2)});
    #1;
    s0 = peripheral_select_zero;
  end

  // watchdog: the whole run needs well under 10000 cycles
  initial
  begin
    #500000;
    n_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    test_done();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sample = 16'hA5C3;
    s0 = 1'b0;
    gap_ok = 1'b0;
    dly = 5;
    rises = 0;
    n_errors = 0;
    compares = 0;
    t_rel = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, clamp of the clock half period, unmapped place
    bus(1'b0, sahl_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, sahl_pkg::OFS_DELAY, 32'h0);
    chk("delay reset", 32'h0000076C, rd);
    bus(1'b0, sahl_pkg::OFS_HALF, 32'h0);
    chk("half reset", 32'h0000000B, rd);
    bus(1'b1, sahl_pkg::OFS_HALF, 32'h00000020);
    bus(1'b0, sahl_pkg::OFS_HALF, 32'h0);
    chk("half clamp", 32'h0000000B, rd);
    bus(1'b1, sahl_pkg::OFS_HALF, 32'h00000000);
    bus(1'b0, sahl_pkg::OFS_HALF, 32'h0);
    chk("half zero", 32'h00000001, rd);
    bus(1'b1, sahl_pkg::OFS_HALF, 32'h0000000B);
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, sahl_pkg::OFS_DELAY, 32'h00000005);
    $display("test registers done");
    // host-initiated queue: two words prove the wrap
    bus(1'b1, sahl_pkg::OFS_CTRL, 32'h00000003);
    @(negedge peripheral_select_zero);
    #5;
    sample = 16'h5A3C;
    wait_valid();
    bus(1'b0, sahl_pkg::OFS_RESULT, 32'h0);
    chk("first word", 32'h0000A5C3, rd);
    wait_valid();
    bus(1'b0, sahl_pkg::OFS_RESULT, 32'h0);
    chk("wrapped word", 32'h00005A3C, rd);
    bus(1'b1, sahl_pkg::OFS_CTRL, 32'h0);
    rd = 32'h4;
    while (rd[sahl_pkg::ST_ACTIVE] !== 1'b0) bus(1'b0, sahl_pkg::OFS_STATUS, 32'h0);
    chk("selects idle", 32'h3, {30'h0, peripheral_select_one, peripheral_select_zero});
    $display("test host queue done");
    // converter as master: frame before arming is ignored, next one is taken
    start_sample_n.frame(16'h1234);
    bus(1'b0, sahl_pkg::OFS_STATUS, 32'h0);
    chk("no word unarmed", 32'h0, rd);
    bus(1'b1, sahl_pkg::OFS_CTRL, 32'h00000001);
    start_sample_n.frame(16'hC35A);
    wait_valid();
    chk("status listening", 32'h0000000D, rd);
    bus(1'b0, sahl_pkg::OFS_RESULT, 32'h0);
    chk("master word", 32'h0000C35A, rd);
    $display("test converter master done");
    test_done();
  end
endmodule : tb
